// ===== src/timer_pwm_cmp.sv
// Contract
// R1: Control bits 7-4 pick timer clock: off, system, high RC, oscillator, low RC, comparator.
// R2: Codes 8-D count rising/falling edges of A0, B0, A4; others reserved.
// R3: Control bits 3-2 route output: off, B2, A3, B4.
// R4: Control bit 1 selects period (0) or PWM (1) mode, reset 0.
// R5: Control bit 0 inverts the timer output before the pin.
// R6: Counter is 8-bit, readable and writable, reset to zero.
// R7: Scaler bit 7 selects 8-bit or build-option 6/7-bit PWM resolution.
// R8: Scaler bits 6-5 prescale by 1, 4, 16 or 64.
// R9: Scaler bits 4-0 hold write-only 5-bit scaler, reset zero.
// R10: Comparator control bit 7 enables the comparator, reset 0.
// R11: Comparator control bit 6 reads result: 1 when plus exceeds minus.
// R12: Comparator bit 5 samples result with the timer clock tick.
// R13: Comparator bit 4 inverts the result polarity.
// R14: Comparator bits 3-1 select minus input; 11X reserved.
// R15: Comparator bit 0 selects plus input: ladder or A4.
// R16: Selection bit 7 drives comparator output onto A0.
// R17: Selection bit 6 enables wake-up on comparator result change.
// R18: Selection bits 5,4 choose ladder ranges; bits 3-0 set level.
// R19: Write-only 8-bit bound register, reset zero, sets compare limit.
// R20: Counter steps per prescaled, scaled tick; output toggles at bound.
// R21: PWM wraps at resolution; high while counter below bound.
//
// Our own choice: the APB interface to the registers.
`include "tpc_defs.svh"
module timer_pwm_cmp #(
   parameter logic RES_SEVEN_BIT = 1'b0,  // pwm_resolution_build_option
   parameter logic HRC_DOUBLE    = 1'b0   // high_rc_doubling_build_option
) (
   input  wire logic                 clock,
   input  wire logic                 arst_n,
   input  wire logic                 clkEn,
   input  wire tpc_pkg::tpc_apb_req_t apbReq,
   output      tpc_pkg::tpc_apb_rsp_t apbRsp,
   input  wire tpc_pkg::tpc_clk_in_t clkIn,
   input  wire logic                 cmpRaw,
   output      tpc_pkg::tpc_analog_t analogCtl,
   output      tpc_pkg::tpc_pins_t   pinOut,
   output      tpc_pkg::tpc_pins_t   pinOe,
   output      logic                 cmpPinOut,
   output      logic                 cmpPinOe,
   output      logic                 wakeUp
);
   import tpc_pkg::*;

   logic [7:0] ctlReg, cntReg, sclReg, bndReg, cmpCtlReg, cmpSelReg;
   logic [7:0] cntNext;
   logic [5:0] preReg;
   logic [4:0] divReg;
   logic       outReg, cmpSmpReg, cmpPrevReg, wakeReg;
   logic       rdReg;
   logic [7:0] rdData;
   logic [6:0] inPrev;

   function automatic logic rise(input logic cur, input logic prev);
      return cur & ~prev;
   endfunction

   // Register access
   wire        apbAcc   = apbReq.psel & apbReq.penable;
   wire        apbWr    = apbAcc & apbReq.pwrite & clkEn;
   wire [9:0]  wordIdx  = apbReq.paddr[11:2];
   wire        selCc    = wordIdx == {2'h0, `TPC_IDX_CMP_CTL};
   wire        selCs    = wordIdx == {2'h0, `TPC_IDX_CMP_SEL};
   wire        selTc    = wordIdx == {2'h0, `TPC_IDX_TMR_CTL};
   wire        selCt    = wordIdx == {2'h0, `TPC_IDX_TMR_CNT};
   wire        selSc    = wordIdx == {2'h0, `TPC_IDX_TMR_SCL};
   wire        selBd    = wordIdx == {2'h0, `TPC_IDX_TMR_BND};
   wire        mapped   = selCc | selCs | selTc | selCt | selSc | selBd;
   wire        wrCt     = apbWr & selCt;

   // Comparator result path
   wire        cmpRes   = cmpCtlReg[7] & cmpRaw;  // R11
   wire        cmpPol   = cmpRes ^ cmpCtlReg[4];  // R13

   // Clock source selection and edge detection
   wire [6:0]  inCur    = {clkIn.internalHighRcClock, clkIn.externalOscillator, clkIn.internalLowRcClock,
                           clkIn.portABitZero, clkIn.portBBitZero, clkIn.portABitFour, cmpPol};
   wire [3:0]  srcSel   = ctlReg[7:4];
   logic       srcTick;
   always_comb begin
      case (srcSel) // R1 R2
         `TPC_SRC_OFF:   srcTick = 1'b0;
         `TPC_SRC_SYS:   srcTick = 1'b1;
         `TPC_SRC_HRC:   srcTick = HRC_DOUBLE ? (inCur[6] ^ inPrev[6]) : rise(inCur[6], inPrev[6]);
         `TPC_SRC_EXTERNAL_OSCILLATOR:  srcTick = rise(inCur[5], inPrev[5]);
         `TPC_SRC_LRC:   srcTick = rise(inCur[4], inPrev[4]);
         `TPC_SRC_CMP:   srcTick = rise(inCur[0], inPrev[0]);
         `TPC_SRC_PA0_R: srcTick = rise(inCur[3], inPrev[3]);
         `TPC_SRC_PA0_F: srcTick = rise(inPrev[3], inCur[3]);
         `TPC_SRC_PB0_R: srcTick = rise(inCur[2], inPrev[2]);
         `TPC_SRC_PB0_F: srcTick = rise(inPrev[2], inCur[2]);
         `TPC_SRC_PA4_R: srcTick = rise(inCur[1], inPrev[1]);
         `TPC_SRC_PA4_F: srcTick = rise(inPrev[1], inCur[1]);
         default:        srcTick = 1'b0;
      endcase
   end

   // Prescaler 1/4/16/64
   logic [5:0] preMask;
   always_comb begin
      case (sclReg[6:5]) // R8
         2'h0:    preMask = 6'h00;
         2'h1:    preMask = 6'h03;
         2'h2:    preMask = 6'h0F;
         default: preMask = 6'h3F;
      endcase
   end
   wire        preTick  = srcTick & ((preReg & preMask) == preMask);
   wire        divTick  = preTick & (divReg == sclReg[4:0]);  // R9 R20
   wire        tmrTick  = divTick & ~wrCt;

   // Counter limit and output
   wire [7:0]  resMask  = ~sclReg[7] ? 8'hFF : (RES_SEVEN_BIT ? 8'h7F : 8'h3F);  // R7
   wire        pwmMode  = ctlReg[1];  // R4
   wire        atBound  = cntReg == bndReg;
   always_comb begin
      cntNext = cntReg;
      if (wrCt) begin
         cntNext = apbReq.pwdata[7:0];  // R6
      end else if (tmrTick) begin
         if (pwmMode) begin
            cntNext = (cntReg + 8'h01) & resMask;  // R21
         end else if (atBound) begin
            cntNext = `TPC_RST_BYTE;  // R20
         end else begin
            cntNext = cntReg + 8'h01;  // R20
         end
      end
   end
   wire        pwmLevel = (cntReg & resMask) < bndReg;  // R21
   wire        tmrLevel = (pwmMode ? pwmLevel : outReg) ^ ctlReg[0];  // R5
   wire [1:0]  route    = ctlReg[3:2];

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctlReg    <= `TPC_RST_BYTE;
         sclReg    <= `TPC_RST_BYTE;
         bndReg    <= `TPC_RST_BYTE;  // R19
         cmpCtlReg <= `TPC_RST_BYTE;  // R10
         cmpSelReg <= `TPC_RST_BYTE;
      end else if (apbWr) begin
         if (selTc) ctlReg <= apbReq.pwdata[7:0];
         if (selSc) sclReg <= apbReq.pwdata[7:0];
         if (selBd) bndReg <= apbReq.pwdata[7:0];  // R19
         if (selCc) cmpCtlReg <= {apbReq.pwdata[7], 1'b0, apbReq.pwdata[5:0]};  // R10 R12 R14 R15
         if (selCs) cmpSelReg <= apbReq.pwdata[7:0];  // R16 R17 R18
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cntReg <= `TPC_RST_BYTE;
         preReg <= 6'h00;
         divReg <= 5'h00;
         outReg <= 1'b0;
      end else if (clkEn) begin
         cntReg <= cntNext;
         if (srcTick) preReg <= preReg + 6'h01;
         if (preTick) divReg <= (divReg == sclReg[4:0]) ? 5'h00 : divReg + 5'h01;
         if (tmrTick && !pwmMode && atBound) outReg <= ~outReg;  // R20
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         inPrev     <= 7'h00;
         cmpSmpReg  <= 1'b0;
         cmpPrevReg <= 1'b0;
         wakeReg    <= 1'b0;
         rdReg      <= 1'b0;
      end else if (clkEn) begin
         inPrev     <= inCur;
         if (tmrTick) cmpSmpReg <= cmpPol;  // R12
         cmpPrevReg <= cmpRes;
         wakeReg    <= cmpSelReg[6] & (cmpRes ^ cmpPrevReg);  // R17
         rdReg      <= apbReq.psel & ~apbReq.penable;
      end
   end

   // Sampled result lags the live one by up to a timer tick
   wire        cmpOut   = cmpCtlReg[5] ? cmpSmpReg : cmpPol;  // R12

   always_comb begin
      // Full word index compared so aliased words read zero too
      case (wordIdx)
         {2'h0, `TPC_IDX_CMP_CTL}: rdData = {cmpCtlReg[7], cmpRes, cmpCtlReg[5:0]};  // R11
         {2'h0, `TPC_IDX_TMR_CTL}: rdData = ctlReg;
         {2'h0, `TPC_IDX_TMR_CNT}: rdData = cntReg;  // R6
         default:                  rdData = 8'h00;  // Write-only registers read zero
      endcase
   end

   logic [7:0] rdDataReg;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdDataReg <= 8'h00;
      end else if (clkEn && apbReq.psel && !apbReq.penable) begin
         rdDataReg <= rdData;
      end
   end

   assign apbRsp.pready  = clkEn;
   assign apbRsp.pslverr = apbAcc & ~mapped;
   assign apbRsp.prdata  = {24'h000000, rdDataReg};

   assign analogCtl.enable       = cmpCtlReg[7];  // R10
   assign analogCtl.minusSel     = cmpCtlReg[3:1];  // R14
   assign analogCtl.plusIsPortA4 = cmpCtlReg[0];  // R15
   assign analogCtl.highRange    = cmpSelReg[5];  // R18
   assign analogCtl.lowRange     = cmpSelReg[4];
   assign analogCtl.ladderLevel  = cmpSelReg[3:0];

   assign pinOe.portBBitTwo   = route == `TPC_OUT_PB2;  // R3
   assign pinOe.portABitThree = route == `TPC_OUT_PA3;  // R3
   assign pinOe.portBBitFour  = route == `TPC_OUT_PB4;  // R3
   assign pinOut.portBBitTwo   = tmrLevel;
   assign pinOut.portABitThree = tmrLevel;
   assign pinOut.portBBitFour  = tmrLevel;
   assign cmpPinOe  = cmpSelReg[7];  // R16
   assign cmpPinOut = cmpOut;
   assign wakeUp    = wakeReg;

   wire unusedBits = apbReq.paddr_unused ^ rdReg;

   period_toggle_a: assert property (@(posedge clock) disable iff (!arst_n)
      clkEn && tmrTick && !pwmMode && atBound && !wrCt |=> outReg != $past(outReg))
      else $error("Output did not toggle at bound");  // R20
   period_wrap_a: assert property (@(posedge clock) disable iff (!arst_n)
      clkEn && tmrTick && !pwmMode && atBound |=> cntReg == 8'h00)
      else $error("Period counter did not restart");  // R20
   pwm_level_a: assert property (@(posedge clock) disable iff (!arst_n)
      pwmMode && !ctlReg[0] |-> tmrLevel == ((cntReg & resMask) < bndReg))
      else $error("PWM level wrong");  // R21
   invert_pin_a: assert property (@(posedge clock) disable iff (!arst_n)
      pwmMode |-> tmrLevel == (pwmLevel ^ ctlReg[0]))
      else $error("Polarity inversion wrong");  // R5
   count_write_a: assert property (@(posedge clock) disable iff (!arst_n)
      clkEn && wrCt |=> cntReg == $past(apbReq.pwdata[7:0]))
      else $error("Counter write lost");  // R6
   off_frozen_a: assert property (@(posedge clock) disable iff (!arst_n)
      srcSel == `TPC_SRC_OFF && !wrCt |=> $stable(cntReg))
      else $error("Disabled timer counted");  // R1
   route_excl_a: assert property (@(posedge clock) disable iff (!arst_n)
      $onehot0({pinOe.portBBitTwo, pinOe.portABitThree, pinOe.portBBitFour}) && ((route == 2'h0) == (pinOe == 3'h0)))
      else $error("Output routing wrong");  // R3
   wake_change_a: assert property (@(posedge clock) disable iff (!arst_n)
      clkEn && cmpSelReg[6] && $changed(cmpRes) |=> wakeUp)
      else $error("Wake-up missed");  // R17
   pwm_wrap_a: assert property (@(posedge clock) disable iff (!arst_n)
      clkEn && pwmMode && sclReg[7] && tmrTick |=> (cntReg & ~resMask) == 8'h00)
      else $error("PWM exceeded resolution");  // R7
   result_read_a: assert property (@(posedge clock) disable iff (!arst_n)
      !cmpCtlReg[7] |-> !cmpRes)
      else $error("Disabled comparator gave result");  // R11
   count_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
      clkEn && !wrCt && !tmrTick |=> $stable(cntReg))
      else $error("Counter moved without tick");  // R20
   reserved_src_a: assert property (@(posedge clock) disable iff (!arst_n)
      srcSel inside {4'h6, 4'h7, 4'hE, 4'hF} |-> !srcTick)
      else $error("Reserved source ticked");  // R2
   freeze_all_a: assert property (@(posedge clock) disable iff (!arst_n)
      !clkEn |=> $stable(cntReg) && $stable(outReg) && $stable(ctlReg) && $stable(wakeUp))
      else $error("State moved while frozen");
   sample_take_a: assert property (@(posedge clock) disable iff (!arst_n)
      clkEn && tmrTick |=> cmpSmpReg == $past(cmpPol))
      else $error("Result sample missed tick");  // R12
   live_result_a: assert property (@(posedge clock) disable iff (!arst_n)
      !cmpCtlReg[5] |-> cmpPinOut == (cmpRes ^ cmpCtlReg[4]))
      else $error("Unsampled result wrong");  // R13
   wake_quiet_a: assert property (@(posedge clock) disable iff (!arst_n)
      clkEn && !cmpSelReg[6] |=> !wakeUp)
      else $error("Wake-up while disabled");  // R17
   bad_word_a: assert property (@(posedge clock) disable iff (!arst_n)
      apbAcc && !mapped |-> apbRsp.pslverr && apbRsp.prdata == 32'h00000000)
      else $error("Unmapped access not refused");

   pwm_run_c:    cover property (@(posedge clock) disable iff (!arst_n) pwmMode && tmrTick && pwmLevel);
   period_hit_c: cover property (@(posedge clock) disable iff (!arst_n) !pwmMode && tmrTick && atBound);
   wake_c:       cover property (@(posedge clock) disable iff (!arst_n) wakeUp);
   edge_src_c:   cover property (@(posedge clock) disable iff (!arst_n) srcSel == `TPC_SRC_PA4_F && tmrTick);
   cnt_write_c:  cover property (@(posedge clock) disable iff (!arst_n) clkEn && wrCt);
endmodule // timer_pwm_cmp

// ===== src/tpc_defs.svh
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH
`define TPC_IDX_CMP_CTL   8'h2B
`define TPC_IDX_CMP_SEL   8'h2C
`define TPC_IDX_TMR_CTL   8'h30
`define TPC_IDX_TMR_CNT   8'h31
`define TPC_IDX_TMR_SCL   8'h32
`define TPC_IDX_TMR_BND   8'h33
`define TPC_SRC_OFF       4'h0
`define TPC_SRC_SYS       4'h1
`define TPC_SRC_HRC       4'h2
`define TPC_SRC_EXTERNAL_OSCILLATOR      4'h3
`define TPC_SRC_LRC       4'h4
`define TPC_SRC_CMP       4'h5
`define TPC_SRC_PA0_R     4'h8
`define TPC_SRC_PA0_F     4'h9
`define TPC_SRC_PB0_R     4'hA
`define TPC_SRC_PB0_F     4'hB
`define TPC_SRC_PA4_R     4'hC
`define TPC_SRC_PA4_F     4'hD
`define TPC_OUT_OFF       2'h0
`define TPC_OUT_PB2       2'h1
`define TPC_OUT_PA3       2'h2
`define TPC_OUT_PB4       2'h3
`define TPC_RST_BYTE      8'h00
`endif

// ===== src/tpc_pkg.sv
package tpc_pkg;
   typedef struct packed {
      logic       paddr_unused;
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } tpc_apb_req_t;
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } tpc_apb_rsp_t;
   typedef struct packed {
      logic internalHighRcClock;
      logic externalOscillator;
      logic internalLowRcClock;
      logic portABitZero;
      logic portABitFour;
      logic portBBitZero;
   } tpc_clk_in_t;
   typedef struct packed {
      logic portBBitTwo;
      logic portABitThree;
      logic portBBitFour;
   } tpc_pins_t;
   typedef struct packed {
      logic       enable;
      logic       plusIsPortA4;
      logic [2:0] minusSel;
      logic       highRange;
      logic       lowRange;
      logic [3:0] ladderLevel;
   } tpc_analog_t;
endpackage

// ===== test/tb_timer_pwm_cmp.sv
`include "tpc_defs.svh"
module tb_timer_pwm_cmp;
   timeunit 1ns;
   timeprecision 1ps;
   import tpc_pkg::*;
   localparam logic [11:0] A_CC = {2'h0, `TPC_IDX_CMP_CTL, 2'h0};
   localparam logic [11:0] A_CS = {2'h0, `TPC_IDX_CMP_SEL, 2'h0};
   localparam logic [11:0] A_TC = {2'h0, `TPC_IDX_TMR_CTL, 2'h0};
   localparam logic [11:0] A_CT = {2'h0, `TPC_IDX_TMR_CNT, 2'h0};
   localparam logic [11:0] A_TS = {2'h0, `TPC_IDX_TMR_SCL, 2'h0};
   localparam logic [11:0] A_TB = {2'h0, `TPC_IDX_TMR_BND, 2'h0};
   logic         clock, arst_n, clkEn, cmpRaw, cmpPinOut, cmpPinOe, wakeUp, p;
   tpc_apb_req_t req;
   tpc_apb_rsp_t rsp;
   tpc_clk_in_t  clkIn;
   tpc_analog_t  ana;
   tpc_pins_t    pOut, pOe;
   int           err_total, num_checks, n;
   logic [9:0]   expQ[$];
   logic [9:0]   e;
   logic [7:0]   cc, cs;

   timer_pwm_cmp #(.RES_SEVEN_BIT(1'b0), .HRC_DOUBLE(1'b0)) u_timer_pwm_cmp (
      .clock(clock), .arst_n(arst_n), .clkEn(clkEn), .apbReq(req), .apbRsp(rsp), .clkIn(clkIn),
      .cmpRaw(cmpRaw), .analogCtl(ana), .pinOut(pOut), .pinOe(pOe), .cmpPinOut(cmpPinOut),
      .cmpPinOe(cmpPinOe), .wakeUp(wakeUp));
   tpc_far_side u_tpc_far_side (.clock(clock), .analogCtl(ana), .clkIn(clkIn), .cmpRaw(cmpRaw));

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
      num_checks++;
      if (s !== x) begin
         err_total++;
         $display("[ERR] %s exp %0h got %0h", nm, x, s);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Expectation queued first; the monitor below pops it at completion
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [8:0] x);
      expQ.push_back({w, x});
      @(posedge clock);
      req <= '{1'b0, 1'b1, 1'b0, w, a, {24'h0, d}};
      @(posedge clock);
      req.penable <= 1'b1;
      @(posedge clock);
      while (rsp.pready !== 1'b1) @(posedge clock);
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask

   always @(posedge clock) begin
      if (req.psel && req.penable && rsp.pready === 1'b1) begin
         e = expQ.pop_front();
         chk("pslverr", {31'h0, e[8]}, {31'h0, rsp.pslverr});
         if (!e[9]) chk("prdata", {24'h0, e[7:0]}, rsp.prdata);
      end
   end

   // High time over one full period must equal bound ticks, or period minus bound ticks when inverted
   task automatic pwm(input logic [1:0] pre, input logic [4:0] scl, input logic res, input logic [1:0] rt,
                      input logic inv);
      int per, h, tk;
      logic [7:0] b;
      b   = 8'($urandom_range(res ? 63 : 255));
      tk  = (scl + 1) * (4 ** pre);
      per = (res ? 64 : 256) * tk;
      h   = 0;
      apb(1'b1, A_TB, b, 9'h0);
      apb(1'b1, A_TS, {res, pre, scl}, 9'h0);
      apb(1'b1, A_TC, {4'h1, rt, 1'b1, inv}, 9'h0);
      repeat (per + 8) @(posedge clock);
      repeat (per) begin
         @(negedge clock);
         h += int'((pOut & pOe) != 3'b000);
      end
      chk("highTime", inv ? per - b * tk : b * tk, h);
      chk("pinOe", {29'h0, rt == 2'h1, rt == 2'h2, rt == 2'h3}, {29'h0, pOe});
      $display("pwm case done");
   endtask

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   initial begin
      repeat (90000) @(posedge clock);
      err_total++;
      $display("[ERR] watchdog exp done got hang");
      stop_test();
   end

   initial begin
      void'($urandom(80));
      arst_n = 1'b0;
      clkEn  = 1'b1;
      req    = '0;
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      apb(1'b0, A_TC, 8'h0, 9'h000);
      apb(1'b0, A_CC, 8'h0, 9'h000);
      apb(1'b0, A_TS, 8'h0, 9'h000);
      apb(1'b1, A_TB, 8'h5A, 9'h000);
      apb(1'b0, A_TB, 8'h0, 9'h000);
      apb(1'b1, 12'h0FC, 8'h11, 9'h100);
      apb(1'b0, 12'h0FC, 8'h0, 9'h100);
      cc = 8'($urandom);
      apb(1'b1, A_CT, cc, 9'h0);
      repeat (20) @(posedge clock);
      apb(1'b0, A_CT, 8'h0, {1'b0, cc});
      $display("register case done");
      for (int i = 0; i < 2; i++) begin
         cc = (8'($urandom) | 8'h80) & 8'hDF;
         if (cc[3:2] == 2'b11) cc[3] = 1'b0;
         cs = {2'b10, 6'($urandom)};
         cs[3] = i[0];
         apb(1'b1, A_CC, cc, 9'h0);
         apb(1'b1, A_CS, cs, 9'h0);
         repeat (3) @(posedge clock);
         apb(1'b0, A_CC, 8'h0, {1'b0, cc[7], cs[3], cc[5:0]});
         @(negedge clock);
         chk("analogCtl", {21'h0, cc[7], cc[0], cc[3:1], cs[5:0]}, {21'h0, ana});
         chk("cmpPin", {30'h0, 1'b1, cs[3] ^ cc[4]}, {30'h0, cmpPinOe, cmpPinOut});
      end
      for (int w = 0; w < 2; w++) begin
         apb(1'b1, A_CS, {1'b1, w[0], 6'h00}, 9'h0);
         repeat (8) @(posedge clock);
         apb(1'b1, A_CS, {1'b1, w[0], 6'h08}, 9'h0);
         n = 0;
         repeat (8) begin
            @(negedge clock);
            n += int'(wakeUp);
         end
         chk("wakePulses", w, n);
      end
      // Take a high result, stop the timer, then drop the live result
      apb(1'b1, A_CC, 8'hA0, 9'h0);
      apb(1'b1, A_TC, 8'h10, 9'h0);
      repeat (4) @(negedge clock);
      apb(1'b1, A_TC, 8'h00, 9'h0);
      apb(1'b1, A_CS, 8'h80, 9'h0);
      repeat (4) @(negedge clock);
      chk("heldResult", 32'h1, {31'h0, cmpPinOut});
      apb(1'b1, A_TC, 8'h10, 9'h0);
      repeat (4) @(negedge clock);
      chk("tickResult", 32'h0, {31'h0, cmpPinOut});
      $display("comparator case done");
      apb(1'b1, A_TS, 8'h00, 9'h0);
      apb(1'b1, A_TB, 8'h09, 9'h0);
      apb(1'b1, A_CT, 8'h00, 9'h0);
      apb(1'b1, A_TC, 8'h14, 9'h0);
      repeat (30) @(posedge clock);
      n = 0;
      repeat (20) begin
         @(negedge clock);
         n += int'(pOut.portBBitTwo & pOe.portBBitTwo);
      end
      chk("periodHigh", 32'hA, n);
      @(posedge clock);
      clkEn <= 1'b0;
      @(negedge clock);
      p = pOut.portBBitTwo;
      repeat (12) @(negedge clock);
      chk("frozenPin", {31'h0, p}, {31'h0, pOut.portBBitTwo});
      @(posedge clock);
      clkEn <= 1'b1;
      $display("period case done");
      for (int k = 0; k < 4; k++) pwm(2'(k), 5'(3 - k), 1'b0, 2'(k % 3 + 1), k[0]);
      pwm(2'h0, 5'h1, 1'b1, 2'h3, 1'b0);
      stop_test();
   end
endmodule // tb_timer_pwm_cmp

// ===== test/tpc_far_side.sv
module tpc_far_side (
   input  wire logic                 clock,
   input  wire tpc_pkg::tpc_analog_t analogCtl,
   output tpc_pkg::tpc_clk_in_t      clkIn,
   output logic                      cmpRaw
);
   timeunit 1ns;
   timeprecision 1ps;
   import tpc_pkg::*;
   // Minus side held near mid scale, so ladder bit 3 decides
   assign cmpRaw = analogCtl.enable & analogCtl.ladderLevel[3];
   // Pins and oscillators wander so unselected sources stay busy
   always @(posedge clock) clkIn <= tpc_clk_in_t'($urandom);
endmodule // tpc_far_side
